/* File: logic/spb_defines.svh */
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH

// register word indices; byte address is four times the index
`define SPB_IDX_CTRL      16'hc0e0
`define SPB_IDX_FLAGS     16'hc0e2
`define SPB_IDX_DATA      16'hc0e4
`define SPB_IDX_IRQ_STAT  16'hc0f0
`define SPB_IDX_IRQ_MASK  16'hc0f2

// control field layout
`define SPB_CTRL_EN_BIT   0
`define SPB_CTRL_SEL_LSB  1
`define SPB_CTRL_SEL_MSB  3
`define SPB_CTRL_BAUD_PRESCALE_BY_EIGHT_BIT 4
`define SPB_CTRL_W        5
`define SPB_CTRL_RESET    5'h00

// flag and interrupt bit positions
`define SPB_FLAG_TXE_BIT  0
`define SPB_FLAG_RXF_BIT  1

// bit timing
`define SPB_CLK_HZ        200000000
`define SPB_BASE_BAUD     115200
`define SPB_OVERSAMPLE    16
`define SPB_OS_RATE       (`SPB_BASE_BAUD * `SPB_OVERSAMPLE)
`define SPB_BASE_DIV      ((`SPB_CLK_HZ + `SPB_OS_RATE / 2) / `SPB_OS_RATE)
`define SPB_PRESCALE_SH   3
`define SPB_OS_LAST       4'hf
`define SPB_OS_MID        4'h7
`define SPB_LAST_BIT      3'h7

`endif

/* File: logic/spb_pkg.sv */
package spb_pkg;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } spb_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } spb_rx_st_t;

  typedef struct packed {
    logic [7:0] base_cnt;
    logic [7:0] mult_cnt;
    logic       tick;
  } spb_baud_state_t;

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [7:0]  tx_hold;
    logic [7:0]  tx_shift;
    logic        tx_empty;
    spb_tx_st_t  tx_st;
    logic [3:0]  tx_os;
    logic [2:0]  tx_bit;
    logic        txd;
    spb_rx_st_t  rx_st;
    logic [3:0]  rx_os;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        ack;
    logic [15:0] rdat;
  } spb_state_t;

  localparam spb_state_t SPB_STATE_RST = '{
    tx_empty: 1'b1,
    txd:      1'b1,
    tx_st:    TX_IDLE,
    rx_st:    RX_IDLE,
    default:  '0
  };

endpackage

/* File: logic/spb_baud_gen.sv */
`timescale 1ns/1ps
`include "spb_defines.svh"

module spb_baud_gen #(
  parameter logic [7:0] BASE_DIV = 8'(`SPB_BASE_DIV)
) (
  input  wire logic       clk_i,      // system clock
  input  wire logic       rst_i,      // sync reset, active high
  input  wire logic       en_i,       // port enabled
  input  wire logic [2:0] rate_sel_i, // baud_rate_select
  input  wire logic       baud_prescale_by_eight_i,     // baud_prescale_by_eight
  output logic            tick_o      // one pulse per sixteenth of a bit
);
  import spb_pkg::*;

  spb_baud_state_t st;
  spb_baud_state_t nxt;

  // ticks of the base 16x rate per 16x tick at the chosen rate
  function automatic logic [7:0] rate_mult(input logic [2:0] sel, input logic baud_prescale_by_eight);
    logic [7:0] m;
    case (sel)
      3'h0:    m = 8'h01;
      3'h1:    m = 8'h02;
      3'h2:    m = 8'h03;
      3'h3:    m = 8'h04;
      3'h4:    m = 8'h06;
      3'h5:    m = 8'h08;
      3'h6:    m = 8'h0c;
      default: m = 8'h10;
    endcase
    rate_mult = baud_prescale_by_eight ? (m << `SPB_PRESCALE_SH) : m;
  endfunction

  // private dividers, untouched by the general timers
  always_comb begin
    nxt      = st;
    nxt.tick = 1'b0;
    if (!en_i) begin
      nxt.base_cnt = 8'h00;
      nxt.mult_cnt = 8'h00;
    end else if (st.base_cnt >= BASE_DIV - 8'h01) begin
      nxt.base_cnt = 8'h00;
      if (st.mult_cnt >= rate_mult(rate_sel_i, baud_prescale_by_eight_i) - 8'h01) begin
        nxt.mult_cnt = 8'h00;
        nxt.tick     = 1'b1;
      end else begin
        nxt.mult_cnt = st.mult_cnt + 8'h01;
      end
    end else begin
      nxt.base_cnt = st.base_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign tick_o = st.tick;

endmodule

/* File: logic/spb_serial_port.sv */
// How it works
// - Line rates from 900 to 115200 baud are chosen through the control register.
// - One-shot interrupt events fire when receive turns full and transmit turns empty.
// - Bit timing comes from dividers owned by this port alone.
// - Serial output goes out on line 28 and serial input comes in on line 27.
// - Control bit 0 enables the port, and when clear both lines act as plain pins.
// - Control bits 3..1 pick 115.2K down to 7.2K, and bit 4 divides that rate by eight.
// - Flags show receive-full in bit 1 and transmit-empty in bit 0, set on shifter load.
// - Received characters get no parity, framing or overrun checking at all.
// - Writing the data word queues its low byte for sending and ignores the rest.
// - Reading the data word returns the last received byte with upper bits zero.
`timescale 1ns/1ps
`include "spb_defines.svh"

module spb_serial_port #(
  parameter logic [7:0] BASE_DIV = 8'(`SPB_BASE_DIV)
) (
  input  wire logic        clk_i,                // system clock, 200 MHz
  input  wire logic        rst_i,                // sync reset, active high
  input  wire logic        wb_cyc_i,             // bus cycle
  input  wire logic        wb_stb_i,             // bus strobe
  input  wire logic        wb_we_i,              // write enable
  input  wire logic [17:0] wb_adr_i,             // byte address
  input  wire logic [3:0]  wb_sel_i,             // byte lane selects
  input  wire logic [31:0] wb_dat_i,             // write data
  output logic      [31:0] wb_dat_o,             // read data
  output logic             wb_ack_o,             // acknowledge
  output logic             irq_o,                // level interrupt
  input  wire logic        general_line_28_i,    // line 28 pin level
  output logic             general_line_28_o,    // line 28 pin drive
  output logic             general_line_28_oe_o, // line 28 drive enable
  input  wire logic        general_line_27_i,    // line 27 pin level
  output logic             general_line_27_o,    // line 27 pin drive
  output logic             general_line_27_oe_o, // line 27 drive enable
  input  wire logic        port_28_out_i,        // pin block drive, line 28
  input  wire logic        port_28_oe_i,         // pin block enable, line 28
  output logic             port_28_in_o,         // line 28 level to pin block
  input  wire logic        port_27_out_i,        // pin block drive, line 27
  input  wire logic        port_27_oe_i,         // pin block enable, line 27
  output logic             port_27_in_o          // line 27 level to pin block
);
  import spb_pkg::*;

  spb_state_t  st;
  spb_state_t  nxt;
  logic        en;
  logic        tick;
  logic        rxd;
  logic        req;
  logic [15:0] widx;
  logic        rd_go;
  logic        wr_go;
  logic        wr_data;
  logic        tx_load;
  logic        rx_done;

  function automatic logic hit(input logic [15:0] idx, input logic [15:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  assign en  = st.ctrl[`SPB_CTRL_EN_BIT];
  assign rxd = general_line_27_i;

  spb_baud_gen #(
    .BASE_DIV (BASE_DIV)
  ) u_baud (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .en_i       (en),
    .rate_sel_i (st.ctrl[`SPB_CTRL_SEL_MSB:`SPB_CTRL_SEL_LSB]),
    .baud_prescale_by_eight_i     (st.ctrl[`SPB_CTRL_BAUD_PRESCALE_BY_EIGHT_BIT]),
    .tick_o     (tick)
  );

  always_comb begin
    nxt     = st;
    req     = wb_cyc_i & wb_stb_i;
    widx    = wb_adr_i[17:2];
    rd_go   = req & ~st.ack & ~wb_we_i;
    wr_go   = req & st.ack & wb_we_i & wb_sel_i[0];
    wr_data = wr_go & hit(widx, `SPB_IDX_DATA);
    tx_load = 1'b0;
    rx_done = 1'b0;

    // answer one cycle after the request, drop it the cycle after
    nxt.ack = req & ~st.ack;

    // reads are captured with their side effects at the request edge
    if (rd_go) begin
      if (hit(widx, `SPB_IDX_CTRL)) begin
        nxt.rdat = {11'h000, st.ctrl};
      end else if (hit(widx, `SPB_IDX_FLAGS)) begin
        nxt.rdat = {14'h0000, st.rx_full, st.tx_empty};
      end else if (hit(widx, `SPB_IDX_DATA)) begin
        nxt.rdat    = {8'h00, st.rx_data};
        nxt.rx_full = 1'b0;
      end else if (hit(widx, `SPB_IDX_IRQ_STAT)) begin
        nxt.rdat     = {14'h0000, st.irq_stat};
        nxt.irq_stat = 2'b00;
      end else if (hit(widx, `SPB_IDX_IRQ_MASK)) begin
        nxt.rdat = {14'h0000, st.irq_mask};
      end else begin
        nxt.rdat = 16'h0000;
      end
    end else if (req && !st.ack) begin
      nxt.rdat = 16'h0000;
    end

    // transmitter
    case (st.tx_st)
      TX_IDLE: begin
        nxt.tx_os  = 4'h0;
        nxt.tx_bit = 3'h0;
        if (en && !st.tx_empty) begin
          nxt.tx_shift = st.tx_hold;
          nxt.tx_empty = 1'b1;
          nxt.tx_st    = TX_START;
          tx_load      = 1'b1;
        end
      end
      TX_START: begin
        if (tick) begin
          nxt.tx_os = st.tx_os + 4'h1;
          if (st.tx_os == `SPB_OS_LAST) begin
            nxt.tx_st = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          nxt.tx_os = st.tx_os + 4'h1;
          if (st.tx_os == `SPB_OS_LAST) begin
            nxt.tx_shift = {1'b0, st.tx_shift[7:1]};
            nxt.tx_bit   = st.tx_bit + 3'h1;
            if (st.tx_bit == `SPB_LAST_BIT) begin
              nxt.tx_st = TX_STOP;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          nxt.tx_os = st.tx_os + 4'h1;
          if (st.tx_os == `SPB_OS_LAST) begin
            nxt.tx_st = TX_IDLE;
          end
        end
      end
      default: begin
        nxt.tx_st = TX_IDLE;
      end
    endcase

    // receiver: samples mid-bit and keeps whatever stop level it sees
    case (st.rx_st)
      RX_IDLE: begin
        nxt.rx_os  = 4'h0;
        nxt.rx_bit = 3'h0;
        if (en && tick && !rxd) begin
          nxt.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          nxt.rx_os = st.rx_os + 4'h1;
          if (st.rx_os == `SPB_OS_MID) begin
            nxt.rx_os = 4'h0;
            nxt.rx_st = rxd ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          nxt.rx_os = st.rx_os + 4'h1;
          if (st.rx_os == `SPB_OS_LAST) begin
            nxt.rx_shift = {rxd, st.rx_shift[7:1]};
            nxt.rx_bit   = st.rx_bit + 3'h1;
            if (st.rx_bit == `SPB_LAST_BIT) begin
              nxt.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          nxt.rx_os = st.rx_os + 4'h1;
          if (st.rx_os == `SPB_OS_LAST) begin
            // no framing or overrun check: byte always lands
            nxt.rx_data = st.rx_shift;
            nxt.rx_full = 1'b1;
            nxt.rx_st   = RX_IDLE;
            rx_done     = 1'b1;
          end
        end
      end
      default: begin
        nxt.rx_st = RX_IDLE;
      end
    endcase

    // a disabled port abandons any frame in flight
    if (!en) begin
      nxt.tx_st = TX_IDLE;
      nxt.rx_st = RX_IDLE;
    end

    // writes take effect at the acknowledge edge; a new byte beats a load
    if (wr_go) begin
      if (hit(widx, `SPB_IDX_CTRL)) begin
        nxt.ctrl = wb_dat_i[`SPB_CTRL_W-1:0];
      end
      if (wr_data) begin
        nxt.tx_hold  = wb_dat_i[7:0];
        nxt.tx_empty = 1'b0;
      end
      if (hit(widx, `SPB_IDX_IRQ_MASK)) begin
        nxt.irq_mask = wb_dat_i[1:0];
      end
    end

    // transition events set sticky bits after any read clear
    if (tx_load) begin
      nxt.irq_stat[`SPB_FLAG_TXE_BIT] = 1'b1;
    end
    if (rx_done && !st.rx_full) begin
      nxt.irq_stat[`SPB_FLAG_RXF_BIT] = 1'b1;
    end

    // line level follows the state being entered
    case (nxt.tx_st)
      TX_START: nxt.txd = 1'b0;
      TX_DATA:  nxt.txd = nxt.tx_shift[0];
      default:  nxt.txd = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= SPB_STATE_RST;
    end else begin
      st <= nxt;
    end
  end

  assign wb_dat_o = {16'h0000, st.rdat};
  assign wb_ack_o = st.ack;
  assign irq_o    = |(st.irq_stat & st.irq_mask);

  // line 28 carries transmit, line 27 is released for receive
  assign general_line_28_o    = en ? st.txd : port_28_out_i;
  assign general_line_28_oe_o = en ? 1'b1 : port_28_oe_i;
  assign general_line_27_o    = port_27_out_i;
  assign general_line_27_oe_o = en ? 1'b0 : port_27_oe_i;
  assign port_28_in_o         = general_line_28_i;
  assign port_27_in_o         = general_line_27_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_after_req: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_flags_read_layout: assert property (
    (wb_ack_o && !wb_we_i && hit(wb_adr_i[17:2], `SPB_IDX_FLAGS))
    |-> (wb_dat_o[31:2] == 30'h0 && wb_dat_o[0] == $past(st.tx_empty)
         && wb_dat_o[1] == $past(st.rx_full)))
    else $error("flags word wrong");

  a_txe_on_load: assert property (
    (en && st.tx_st == TX_IDLE && !st.tx_empty && !wr_data)
    |=> (st.tx_empty && st.tx_st == TX_START))
    else $error("held byte not moved to shifter");

  a_write_queues_byte: assert property (
    wr_data |=> (!st.tx_empty && st.tx_hold == $past(wb_dat_i[7:0])))
    else $error("data write not queued");

  a_rx_read_value: assert property (
    (wb_ack_o && !wb_we_i && hit(wb_adr_i[17:2], `SPB_IDX_DATA))
    |-> (wb_dat_o[31:8] == 24'h0 && wb_dat_o[7:0] == $past(st.rx_data)))
    else $error("receive byte read wrong");

  a_tx_irq_event: assert property (
    tx_load |=> st.irq_stat[`SPB_FLAG_TXE_BIT])
    else $error("transmit empty event lost");

  a_rx_irq_event: assert property (
    (rx_done && !st.rx_full) |=> (st.irq_stat[`SPB_FLAG_RXF_BIT] && st.rx_full))
    else $error("receive full event lost");

  a_pins_released: assert property (
    !en |-> (general_line_28_oe_o == port_28_oe_i
             && general_line_27_oe_o == port_27_oe_i
             && general_line_28_o == port_28_out_i))
    else $error("pins not released while disabled");

  a_start_bit_low: assert property (
    (en && st.tx_st == TX_START) |-> (!general_line_28_o && general_line_28_oe_o))
    else $error("start bit not low");

  a_stop_bit_high: assert property (
    (en && (st.tx_st == TX_STOP || st.tx_st == TX_IDLE)) |-> general_line_28_o)
    else $error("stop or idle level not high");

endmodule

/* File: testbench/spb_host_model.sv */
`timescale 1ns/1ps

module spb_host_model (
  input  wire logic clk_i,     // bench clock
  input  wire logic tx_line_i, // serial line from the port
  output logic      rx_line_o  // serial line into the port
);
  int         bit_clks = 32;
  logic [7:0] got_q[$];
  logic [7:0] sh;

  initial begin
    rx_line_o = 1'b1;
    forever begin
      wait (tx_line_i === 1'b0);
      repeat (bit_clks / 2) @(posedge clk_i);
      if (tx_line_i === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_clks) @(posedge clk_i);
          sh[i] = tx_line_i;
        end
        repeat (bit_clks) @(posedge clk_i);
        if (tx_line_i === 1'b1) begin
          got_q.push_back(sh);
        end
      end
      wait (tx_line_i === 1'b1);
    end
  end

  // start, data lsb first, stop; ends idle high
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rx_line_o <= fr[i];
      repeat (bit_clks - 1) @(posedge clk_i);
    end
  endtask
endmodule

/* File: testbench/spb_serial_port_tb_top.sv */
`timescale 1ns/1ps
`include "spb_defines.svh"

module spb_serial_port_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [17:0] adr   = '0;
  logic [3:0]  sel   = '0;
  logic [31:0] wdat  = '0;
  logic        p28o  = 1'b1;
  logic        p28oe = 1'b0;
  logic        p27o  = 1'b1;
  logic        p27oe = 1'b0;
  wire  [31:0] rdat;
  wire         ack, irq, l28o, l28oe, l27o, l27oe, in28, in27, host_rx;
  // pull-up on line 28, host drives line 27 unless the pin is driven here
  wire         line28 = l28oe ? l28o : 1'b1;
  wire         line27 = l27oe ? l27o : host_rx;
  int          err_total = 0;
  int          total_checks = 0;

  spb_serial_port #(.BASE_DIV(8'h02)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .general_line_28_i(line28), .general_line_28_o(l28o),
    .general_line_28_oe_o(l28oe), .general_line_27_i(line27), .general_line_27_o(l27o),
    .general_line_27_oe_o(l27oe), .port_28_out_i(p28o), .port_28_oe_i(p28oe),
    .port_28_in_o(in28), .port_27_out_i(p27o), .port_27_oe_i(p27oe), .port_27_in_o(in27));

  spb_host_model host (.clk_i(clk_i), .tx_line_i(line28), .rx_line_o(host_rx));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) chk(32'h0, 32'h1, "ack timeout");
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, idx, 16'h0000, q);
    chk(q, e, what);
  endtask

  task automatic wait28(input logic lvl, output int n);
    n = 0;
    while (line28 !== lvl && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) chk(32'h0, 32'h1, "line 28 stuck");
  endtask

  task t_reset;
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rd(`SPB_IDX_CTRL, 32'h0, "ctrl reset");
    rd(`SPB_IDX_FLAGS, 32'h1, "flags reset");
    rd(16'hc0e8, 32'h0, "unmapped read");
    wr(`SPB_IDX_FLAGS, 16'hffff);
    rd(`SPB_IDX_FLAGS, 32'h1, "flags read only");
    wr(`SPB_IDX_CTRL, 16'hffe0);
    rd(`SPB_IDX_CTRL, 32'h0, "ctrl spare bits");
  endtask

  task t_pins;
    p28oe <= 1'b1; p27o <= 1'b0; p27oe <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({28'h0, l28o, l28oe, l27o, l27oe}, 32'hd, "plain pins");
    chk({30'h0, in28, in27}, 32'h2, "pin levels back");
    wr(`SPB_IDX_CTRL, 16'h0001);
    #1;
    chk({28'h0, l28o, l28oe, l27o, l27oe}, 32'hc, "serial pins");
    @(posedge clk_i);
    p28oe <= 1'b0; p27o <= 1'b1; p27oe <= 1'b0;
  endtask

  task t_tx;
    wr(`SPB_IDX_IRQ_MASK, 16'h0001);
    host.got_q.delete();
    wr(`SPB_IDX_DATA, 16'h7ea5);
    wr(`SPB_IDX_DATA, 16'h003c);
    rd(`SPB_IDX_FLAGS, 32'h0, "second byte pending");
    chk({31'h0, irq}, 32'h1, "tx empty irq");
    rd(`SPB_IDX_IRQ_STAT, 32'h1, "tx empty event");
    #1;
    chk({31'h0, irq}, 32'h0, "irq cleared");
    repeat (700) @(posedge clk_i);
    rd(`SPB_IDX_FLAGS, 32'h1, "all sent");
    rd(`SPB_IDX_IRQ_STAT, 32'h1, "second empty event");
    chk(32'(host.got_q.size()), 32'h2, "frame count");
    chk({24'h0, host.got_q[0]}, 32'ha5, "first frame");
    chk({24'h0, host.got_q[1]}, 32'h3c, "second frame");
  endtask

  task t_rate;
    int m[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    int n;
    int w;
    for (int i = 0; i < 9; i++) begin
      w = (i < 8) ? 32 * m[i] : 256;
      host.bit_clks = w;
      wr(`SPB_IDX_CTRL, (i < 8) ? 16'(i * 2 + 1) : 16'h0011);
      wr(`SPB_IDX_DATA, 16'h0001);
      wait28(1'b0, n);
      wait28(1'b1, n);
      wait28(1'b0, n);
      chk(32'(n), 32'(w), "bit width");
      repeat (9 * w) @(posedge clk_i);
    end
    host.bit_clks = 32;
    wr(`SPB_IDX_CTRL, 16'h0001);
  endtask

  task t_rx;
    rd(`SPB_IDX_IRQ_STAT, 32'h1, "rate loads left empty event");
    wr(`SPB_IDX_IRQ_MASK, 16'h0002);
    host.send_byte(8'h3c);
    repeat (40) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1, "rx full irq");
    rd(`SPB_IDX_FLAGS, 32'h3, "rx full flag");
    rd(`SPB_IDX_IRQ_STAT, 32'h2, "rx full event");
    host.send_byte(8'h81);
    repeat (40) @(posedge clk_i);
    rd(`SPB_IDX_IRQ_STAT, 32'h0, "no event while full");
    wr(`SPB_IDX_DATA, 16'h00ff);
    rd(`SPB_IDX_DATA, 32'h81, "last received byte");
    rd(`SPB_IDX_FLAGS, 32'h1, "rx full cleared");
  endtask

  task test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    test_done;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_pins;
    t_tx;
    t_rate;
    t_rx;
    test_done;
  end
endmodule
